// ---- common/dma_chan_pkg.sv ----
// constants, types and register map of the single dma channel
package dma_chan_pkg;

  // ==========================================================================
  // register indices; byte address on the bus is four times the index
  localparam logic [31:0] IDX_ITEM_INDEX   = 32'h5000361E;
  localparam logic [31:0] IDX_SRC_START_LO = 32'h50003620;
  localparam logic [31:0] IDX_SRC_START_HI = 32'h50003622;
  localparam logic [31:0] IDX_DST_START_LO = 32'h50003624;
  localparam logic [31:0] IDX_DST_START_HI = 32'h50003626;
  localparam logic [31:0] IDX_IRQ_THRESH   = 32'h50003628;
  localparam logic [31:0] IDX_LENGTH       = 32'h5000362A;
  localparam logic [31:0] IDX_CONTROL      = 32'h5000362C;

  // ==========================================================================
  // reset values, masks and response codes
  localparam logic [15:0] REG16_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_WMASK   = 16'h3FFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // item width codes
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;

  // ==========================================================================
  // register select codes returned by the address decoder
  typedef enum logic [3:0] {
    SEL_NONE  = 4'b0000,
    SEL_INDEX = 4'b0001,
    SEL_SRCLO = 4'b0010,
    SEL_SRCHI = 4'b0011,
    SEL_DSTLO = 4'b0100,
    SEL_DSTHI = 4'b0101,
    SEL_THR   = 4'b0110,
    SEL_LEN   = 4'b0111,
    SEL_CTRL  = 4'b1000
  } reg_sel_e;

  // transfer engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_TRIG  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b011,
    ST_GAP   = 3'b100
  } eng_state_e;

  // control register layout, msb first
  typedef struct packed {
    logic [1:0] rsvd;
    logic       req_edge;
    logic       fill;
    logic       idle_gap;
    logic [2:0] channel_priority;
    logic       wraparound;
    logic       src_incr;
    logic       dst_incr;
    logic       peripheral_trigger_mode;
    logic       irq_en;
    logic [1:0] item_width_code;
    logic       on;
  } ctrl_s;

  // one system bus command issued by the channel
  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_s;

endpackage

// ---- rtl/dma_chan.sv ----
// one dma channel: axi4-lite register slave and item transfer engine
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module dma_chan
  import dma_chan_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // axi4-lite register slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // system bus master side, request held until ack
  output logic             mem_req,
  output mem_cmd_s         mem_cmd,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             bus_lock,
  output logic [2:0]       channel_priority,
  // peripheral request and channel interrupt
  input  wire logic        periph_req,
  output logic             irq
);

  // ==========================================================================
  // register state
  ctrl_s            ctrl_q;
  logic [15:0]      src_lo_q;
  logic [15:0]      src_hi_q;
  logic [15:0]      dst_lo_q;
  logic [15:0]      dst_hi_q;
  logic [15:0]      thr_q;
  logic [15:0]      len_q;
  logic [15:0]      idx_q;

  // axi slave state
  logic             aw_hold_q;
  logic [31:0]      aw_addr_q;
  logic             w_hold_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;
  logic             awready_q;
  logic             wready_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             arready_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  // engine state
  eng_state_e       state_q;
  logic [31:0]      data_q;
  logic             mem_req_q;
  mem_cmd_s         mem_cmd_q;
  logic             lock_q;
  logic [2:0]       prio_q;
  logic             irq_q;
  logic             req_prev_q;
  logic             edge_pend_q;

  // ==========================================================================
  // functions shared by read and write paths
  function automatic reg_sel_e decode(input logic [31:0] addr);
    reg_sel_e s;
    s = SEL_NONE;
    if (addr == {IDX_ITEM_INDEX[29:0], 2'b00}) begin
      s = SEL_INDEX;
    end else if (addr == {IDX_SRC_START_LO[29:0], 2'b00}) begin
      s = SEL_SRCLO;
    end else if (addr == {IDX_SRC_START_HI[29:0], 2'b00}) begin
      s = SEL_SRCHI;
    end else if (addr == {IDX_DST_START_LO[29:0], 2'b00}) begin
      s = SEL_DSTLO;
    end else if (addr == {IDX_DST_START_HI[29:0], 2'b00}) begin
      s = SEL_DSTHI;
    end else if (addr == {IDX_IRQ_THRESH[29:0], 2'b00}) begin
      s = SEL_THR;
    end else if (addr == {IDX_LENGTH[29:0], 2'b00}) begin
      s = SEL_LEN;
    end else if (addr == {IDX_CONTROL[29:0], 2'b00}) begin
      s = SEL_CTRL;
    end
    return s;
  endfunction

  // byte-lane merge into a 16-bit register; upper lanes have no storage
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  // item address from base, index, increment enable and width
  function automatic logic [31:0] item_addr(input logic [31:0] base, input logic inc,
                                            input logic [15:0] idx, input logic [1:0] w);
    logic [31:0] off;
    off = {16'h0000, idx};
    if (!inc) begin
      return base;
    end else if (w == WIDTH_BYTE) begin
      return base + off;
    end else if (w == WIDTH_HALF) begin
      return base + {off[30:0], 1'b0};
    end
    return base + {off[29:0], 2'b00};
  endfunction

  // ==========================================================================
  // combinational helpers
  reg_sel_e    wr_sel;
  reg_sel_e    rd_sel;
  logic        wr_fire;
  logic [31:0] src_base;
  logic [31:0] dst_base;
  logic        item_done;
  logic        last_item;
  logic        rewind;
  logic        finish;
  logic        req_rise;
  logic        go_req;
  logic        eng_en;
  logic [15:0] nxt_idx;

  assign wr_sel    = decode(aw_addr_q);
  assign rd_sel    = decode(s_axi_araddr);
  assign wr_fire   = aw_hold_q & w_hold_q & ~bvalid_q;
  assign src_base  = {src_hi_q, src_lo_q};
  assign dst_base  = {dst_hi_q, dst_lo_q};
  assign item_done = (state_q == ST_WRITE) & mem_req_q & mem_ack;
  assign last_item = (idx_q == len_q);
  // wraparound only counts when peripheral triggered
  assign rewind    = ctrl_q.wraparound & ctrl_q.peripheral_trigger_mode;
  assign finish    = item_done & last_item & ~rewind;
  assign nxt_idx   = last_item ? 16'h0000 : idx_q + 16'h0001;
  assign req_rise  = periph_req & ~req_prev_q;
  assign go_req    = ctrl_q.req_edge ? edge_pend_q : periph_req;
  // engine flops only tick while enabled or finishing an item in flight
  assign eng_en    = ce & (ctrl_q.on | (state_q != ST_IDLE));

  // ==========================================================================
  // axi write address and data capture; either may arrive first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      awready_q <= 1'b0;
    end else if (ce) begin
      if (awready_q && s_axi_awvalid) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end else if (!aw_hold_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      wready_q <= 1'b0;
    end else if (ce) begin
      if (wready_q && s_axi_wvalid) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end else if (!w_hold_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // address, threshold and length registers; index register ignores writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_lo_q <= REG16_RESET;
      src_hi_q <= REG16_RESET;
      dst_lo_q <= REG16_RESET;
      dst_hi_q <= REG16_RESET;
      thr_q    <= REG16_RESET;
      len_q    <= REG16_RESET;
    end else if (ce && wr_fire) begin
      if (wr_sel == SEL_SRCLO) begin
        src_lo_q <= merge16(src_lo_q, w_data_q, w_strb_q);
      end else if (wr_sel == SEL_SRCHI) begin
        src_hi_q <= merge16(src_hi_q, w_data_q, w_strb_q);
      end else if (wr_sel == SEL_DSTLO) begin
        dst_lo_q <= merge16(dst_lo_q, w_data_q, w_strb_q);
      end else if (wr_sel == SEL_DSTHI) begin
        dst_hi_q <= merge16(dst_hi_q, w_data_q, w_strb_q);
      end else if (wr_sel == SEL_THR) begin
        thr_q <= merge16(thr_q, w_data_q, w_strb_q);
      end else if (wr_sel == SEL_LEN) begin
        len_q <= merge16(len_q, w_data_q, w_strb_q);
      end
    end
  end

  // control register; a software write in the finishing cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= ctrl_s'(REG16_RESET);
    end else if (ce) begin
      if (wr_fire && wr_sel == SEL_CTRL) begin
        ctrl_q <= ctrl_s'(merge16(ctrl_q, w_data_q, w_strb_q) & CTRL_WMASK);
      end else if (finish) begin
        ctrl_q.on <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // axi read: data one cycle after the address is taken
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (arready_q && s_axi_arvalid) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        case (rd_sel)
          SEL_INDEX: rdata_q <= {16'h0000, idx_q};
          SEL_SRCLO: rdata_q <= {16'h0000, src_lo_q};
          SEL_SRCHI: rdata_q <= {16'h0000, src_hi_q};
          SEL_DSTLO: rdata_q <= {16'h0000, dst_lo_q};
          SEL_DSTHI: rdata_q <= {16'h0000, dst_hi_q};
          SEL_THR:   rdata_q <= {16'h0000, thr_q};
          SEL_LEN:   rdata_q <= {16'h0000, len_q};
          SEL_CTRL:  rdata_q <= {16'h0000, 16'(ctrl_q) & CTRL_WMASK};
          default:   rdata_q <= 32'h00000000;
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // peripheral request sensing; a new edge wins over the consume
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_prev_q  <= 1'b0;
      edge_pend_q <= 1'b0;
    end else if (ce) begin
      req_prev_q <= periph_req;
      if (req_rise) begin
        edge_pend_q <= 1'b1;
      end else if (eng_en && state_q == ST_TRIG) begin
        edge_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // transfer engine: one item is a read (skipped in fill mode unless the index is 0)
  // then a write; disabling only takes effect between items so no bus
  // request is ever dropped half way
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      idx_q     <= REG16_RESET;
      data_q    <= 32'h00000000;
      mem_req_q <= 1'b0;
      mem_cmd_q <= '0;
    end else if (eng_en) begin
      case (state_q)
        ST_IDLE: begin
          idx_q <= REG16_RESET;
          if (ctrl_q.peripheral_trigger_mode) begin
            state_q <= ST_TRIG;
          end else begin
            state_q        <= ST_READ;
            mem_req_q      <= 1'b1;
            mem_cmd_q.we   <= 1'b0;
            mem_cmd_q.size <= ctrl_q.item_width_code;
            mem_cmd_q.addr <= item_addr(src_base, ctrl_q.src_incr & ~ctrl_q.fill,
                                        REG16_RESET, ctrl_q.item_width_code);
          end
        end
        ST_TRIG, ST_GAP: begin
          if (!ctrl_q.on) begin
            state_q <= ST_IDLE;
          end else if (state_q == ST_GAP || go_req) begin
            mem_req_q      <= 1'b1;
            mem_cmd_q.size <= ctrl_q.item_width_code;
            if (ctrl_q.fill && idx_q != REG16_RESET) begin
              state_q         <= ST_WRITE;
              mem_cmd_q.we    <= 1'b1;
              mem_cmd_q.wdata <= data_q;
              mem_cmd_q.addr  <= item_addr(dst_base, ctrl_q.dst_incr, idx_q,
                                           ctrl_q.item_width_code);
            end else begin
              state_q        <= ST_READ;
              mem_cmd_q.we   <= 1'b0;
              mem_cmd_q.addr <= item_addr(src_base, ctrl_q.src_incr & ~ctrl_q.fill,
                                          idx_q, ctrl_q.item_width_code);
            end
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            state_q         <= ST_WRITE;
            data_q          <= mem_rdata;
            mem_cmd_q.we    <= 1'b1;
            mem_cmd_q.wdata <= mem_rdata;
            mem_cmd_q.addr  <= item_addr(dst_base, ctrl_q.dst_incr, idx_q,
                                         ctrl_q.item_width_code);
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            idx_q     <= nxt_idx;
            mem_req_q <= 1'b0;
            if (last_item && !rewind) begin
              state_q <= ST_IDLE;
            end else if (!ctrl_q.on) begin
              state_q <= ST_IDLE;
            end else if (ctrl_q.peripheral_trigger_mode) begin
              state_q <= ST_TRIG;
            end else if (ctrl_q.idle_gap) begin
              state_q <= ST_GAP;
            end else if (ctrl_q.fill) begin
              state_q         <= ST_WRITE;
              mem_req_q       <= 1'b1;
              mem_cmd_q.wdata <= data_q;
              mem_cmd_q.addr  <= item_addr(dst_base, ctrl_q.dst_incr, nxt_idx,
                                           ctrl_q.item_width_code);
            end else begin
              state_q        <= ST_READ;
              mem_req_q      <= 1'b1;
              mem_cmd_q.we   <= 1'b0;
              mem_cmd_q.addr <= item_addr(src_base, ctrl_q.src_incr, nxt_idx,
                                          ctrl_q.item_width_code);
            end
          end
        end
        default: begin
          state_q   <= ST_IDLE;
          mem_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // bus ownership: priority goes to the external arbiter; the lock keeps
  // lower masters and other channels off while blocking or filling
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_q <= 1'b0;
      prio_q <= 3'h0;
    end else if (ce) begin
      prio_q <= ctrl_q.channel_priority;
      if (!ctrl_q.on && state_q == ST_IDLE) begin
        lock_q <= 1'b0;
      end else if (ctrl_q.fill) begin
        lock_q <= 1'b1;
      end else begin
        lock_q <= ~ctrl_q.peripheral_trigger_mode & ~ctrl_q.idle_gap;
      end
    end
  end

  // interrupt pulse judged on the index before it advances;
  // kept outside the gated engine so the pulse always drops again
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= item_done & ctrl_q.irq_en & (thr_q == idx_q);
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign s_axi_rvalid     = rvalid_q;
  assign mem_req          = mem_req_q;
  assign mem_cmd          = mem_cmd_q;
  assign bus_lock         = lock_q;
  assign channel_priority = prio_q;
  assign irq              = irq_q;

endmodule

// ---- verif/dma_chan_properties.sv ----
// port-level assertions for the dma channel
`timescale 1ns/1ps
module dma_chan_properties
  import dma_chan_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        mem_req,
  input wire mem_cmd_s    mem_cmd,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // engine side: held commands, read-then-write pairing, interrupt pulse
  a_cmd_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("command changed before ack");
  a_rd_then_wr: assert property (mem_req && mem_ack && !mem_cmd.we |=>
                                 mem_req && mem_cmd.we)
    else $error("read not followed by write");
  a_copy_value: assert property (mem_req && mem_ack && !mem_cmd.we |=>
                                 mem_cmd.wdata == $past(mem_rdata))
    else $error("written value differs from read");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (irq |-> $past(mem_req && mem_ack && mem_cmd.we))
    else $error("interrupt without finished item");
  // ==========================================================================
  // register slave side
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_irq: cover property (irq);
  c_store: cover property (mem_req && mem_ack && mem_cmd.we);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind dma_chan dma_chan_properties chk (.*);

// ---- verif/mem_slave_model.sv ----
// system bus slave model: random wait per command, data only valid with ack
`timescale 1ns/1ps
module mem_slave_model
  import dma_chan_pkg::*;
(
  input wire logic     ref_clk,
  input wire logic     rst,
  input wire logic     mem_req,
  input wire mem_cmd_s mem_cmd,
  output logic         mem_ack,
  output logic [31:0]  mem_rdata
);
  int  wait_q = 0;
  wire hit = !rst && mem_req && !mem_ack && wait_q == 0;
  // ==========================================================================
  // answer 1 to 4 cycles after the request; a released data bus toggles so stale data never matches
  always @(posedge ref_clk) begin
    mem_ack <= hit;
    mem_rdata <= rst ? 32'h0 : hit ? mem_cmd.addr ^ 32'h5A5A0000 : ~mem_rdata;
    wait_q <= mem_req && !mem_ack && wait_q > 0 ? wait_q - 1 : $urandom_range(3, 0);
  end
endmodule

// ---- verif/test_dma_channel_regs_and_sequencing.sv ----
// self-checking bench for one dma channel: registers, transfers, triggers
`timescale 1ns/1ps
module test_dma_channel_regs_and_sequencing
  import dma_chan_pkg::*;
;
  logic        ref_clk = 0, rst = 1, ce = 1, periph_req = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, mem_req, mem_ack, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_lock;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, mem_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  channel_priority;
  mem_cmd_s    mem_cmd, exp_q[$];
  int          err_count = 0, samples_checked = 0, cycles = 0, irq_cnt = 0, gap_cnt = 0;
  logic        wr_ack_q = 0, lock_x = 0;

  dma_chan uut (.*);
  mem_slave_model far_end (.*);
  always #12.5 ref_clk = ~ref_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [66:0] got, input logic [66:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ==========================================================================
  // monitor: each accepted command must be the next expected; also counts gaps and pulses
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin err_count++; conclude(); end
    irq_cnt += irq;
    gap_cnt += wr_ack_q && !mem_req;
    wr_ack_q <= mem_req && mem_ack && mem_cmd.we;
    if (mem_req && mem_ack) begin
      chk(bus_lock, lock_x);
      chk({mem_cmd.we, mem_cmd.size, mem_cmd.addr, mem_cmd.wdata & {32{mem_cmd.we}}},
          exp_q.size() ? exp_q.pop_front() : '1);
    end
  end
  // ==========================================================================
  // axi4-lite master: address and data together, each released on its own handshake
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a[29:0], 2'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= {a[29:0], 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask
  // ==========================================================================
  // one transfer: expected commands from start addresses, width and increments
  function automatic logic [31:0] step(input logic [31:0] b, input logic inc, input int i,
                                       input int st);
    return b + (inc ? i * st : 0);
  endfunction
  task automatic run(input logic [15:0] ctl, input logic [15:0] len, input logic [15:0] thr);
    logic [31:0] s, d, ra;
    int st, n;
    s = $urandom;
    d = $urandom;
    st = 1 << ctl[2:1];
    repeat (ctl[7] ? 2 : 1) for (int i = 0; i <= len; i++) begin
      ra = step(s, ctl[6], i, st);
      if (!ctl[12] || i == 0) exp_q.push_back({1'h0, ctl[2:1], ra, 32'h0});
      exp_q.push_back({1'h1, ctl[2:1], step(d, ctl[5], i, st),
                       (ctl[12] ? s : ra) ^ 32'h5A5A0000});
    end
    n = exp_q.size();
    // triggered channels lock only when filling, whatever the idle bit says
    lock_x = (!ctl[11] && !ctl[4]) || ctl[12];
    periph_req <= ctl[13];
    {irq_cnt, gap_cnt} = 0;
    wr(IDX_SRC_START_LO, s[15:0], RESP_OKAY);
    wr(IDX_SRC_START_HI, s[31:16], RESP_OKAY);
    wr(IDX_DST_START_LO, d[15:0], RESP_OKAY);
    wr(IDX_DST_START_HI, d[31:16], RESP_OKAY);
    wr(IDX_IRQ_THRESH, thr, RESP_OKAY);
    wr(IDX_LENGTH, len, RESP_OKAY);
    wr(IDX_CONTROL, ctl, RESP_OKAY);
    // priority flop follows the control register one cycle later
    @(posedge ref_clk);
    chk(channel_priority, ctl[10:8]);
    if (ctl[4]) begin
      repeat (20) @(posedge ref_clk);
      chk(exp_q.size(), n);
      // a request while the clock enable is low must not start anything
      {ce, periph_req} <= 2'h1;
      repeat (8) @(posedge ref_clk);
      chk(exp_q.size(), n);
      ce <= 1'h1;
      repeat (ctl[7] ? 2 : 1) begin
        periph_req <= 1'h0;
        repeat (2) @(posedge ref_clk);
        periph_req <= 1'h1;
        repeat (16) @(posedge ref_clk);
      end
    end
    do rd(IDX_CONTROL, RESP_OKAY, v); while (v[0] && !ctl[7]);
    chk(v[0], ctl[7]);
    rd(IDX_ITEM_INDEX, RESP_OKAY, v);
    chk(v, 0);
    chk(exp_q.size(), 0);
    chk(irq_cnt, (ctl[7] ? 2 : 1) * (ctl[3] && thr <= len));
    if (!ctl[4]) chk(gap_cnt, ctl[11] ? len + 1 : 1);
    wr(IDX_CONTROL, 16'h0000, RESP_OKAY);
  endtask

  initial begin
    logic [31:0] regs [8];
    logic [15:0] c;
    regs = '{IDX_ITEM_INDEX, IDX_SRC_START_LO, IDX_SRC_START_HI, IDX_DST_START_LO,
             IDX_DST_START_HI, IDX_IRQ_THRESH, IDX_LENGTH, IDX_CONTROL};
    void'($urandom(32'hC76A6EC1));
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    foreach (regs[k]) begin
      rd(regs[k], RESP_OKAY, v);
      chk(v, REG16_RESET);
    end
    for (int k = 1; k < 7; k++) begin
      c = $urandom;
      wr(regs[k], {16'hABCD, c}, RESP_OKAY);
      rd(regs[k], RESP_OKAY, v);
      chk(v, c);
    end
    wr(IDX_ITEM_INDEX, 32'hFFFF, RESP_OKAY);
    rd(IDX_ITEM_INDEX, RESP_OKAY, v);
    chk(v, 0);
    wr(IDX_CONTROL + 32'h1, 32'h1, RESP_SLVERR);
    rd(IDX_CONTROL + 32'h1, RESP_SLVERR, v);
    c = $urandom | 16'hC000;
    wr(IDX_CONTROL, c & 16'hFFFE, RESP_OKAY);
    rd(IDX_CONTROL, RESP_OKAY, v);
    chk(v, c & CTRL_WMASK & 16'hFFFE);
    wr(IDX_CONTROL, 16'h0000, RESP_OKAY);
    // random memory-to-memory runs over width codes 0 to 2, fill and idle mixed in
    for (int i = 0; i < 12; i++) begin
      // mask keeps the trigger bit clear, so fill never meets peripheral triggering
      c = $urandom & 16'h1F6E;
      c[2:1] = 2'(i % 3);
      c[12] = i % 4 == 3;
      c[5] = c[5] | c[12];
      run(c | 16'h0001, 16'(i ? $urandom_range(3, 0) : 0), 16'($urandom_range(4, 0)));
    end
    run(16'h0031, 16'h0001, 16'h0000);
    run(16'h2831, 16'h0000, 16'h0000);
    run(16'h20B9, 16'h0000, 16'h0000);
    conclude();
  end
endmodule
